// ### dv/tb_transceiver_reset_control.sv
// testbench: sequencer run, pin fan-out, bonding, registers and busy
`timescale 1ns/1ps
`default_nettype none
`include "trc_regs.vh"
module tb_transceiver_reset_control;
  localparam int N = 8;
  localparam int CAL = 4;
  localparam int RC = 3;
  localparam int PR = 2;
  localparam logic [31:0] ST_EXP [3] = '{32'h0001fe05, 32'h0002ff05, 32'h0000fe05};
  logic ref_clk, sys_rst, hsel, hwrite, block_powerdown, pll_pin, pll_lock_raw, start;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [N-1:0] tb_tx, tb_rx, tb_rxa, cdr_lock_raw, reference_lock_mode, data_lock_mode;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, pll_rst_out, pll_locked, busy, seq_pll, done;
  wire logic [N-1:0] seq_tx, seq_rx, seq_rxa, tx_pcs_rst, rx_pcs_rst, cdr_rst;
  wire logic [N-1:0] tx_buf_pd, rx_buf_pd, deser_pd, freq_locked;
  wire logic [N-1:0] tx_digital_reset = seq_tx | tb_tx;
  wire logic [N-1:0] rx_digital_reset = seq_rx | tb_rx;
  wire logic [N-1:0] rx_analog_reset = seq_rxa | tb_rxa;
  wire logic pll_reset = seq_pll | pll_pin;
  int error_cnt, checked, n, m;
  trc_top #(.CHANNELS(N), .CAL_CYC(CAL), .RCFG_CYC(RC), .PLLR_CYC(PR)) u_dut (
    .ref_clk, .sys_rst, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .tx_digital_reset,
    .rx_digital_reset, .rx_analog_reset, .block_powerdown, .pll_reset, .pll_lock_raw,
    .cdr_lock_raw, .reference_lock_mode, .data_lock_mode, .tx_pcs_rst, .rx_pcs_rst,
    .cdr_rst, .tx_buf_pd, .rx_buf_pd, .deser_pd, .pll_rst_out, .pll_locked,
    .freq_locked, .busy);
  trc_fabric_seq #(.N(N)) u_seq (.clk(ref_clk), .rst(sys_rst), .start, .pll_locked,
    .busy, .freq_locked, .pll_reset(seq_pll), .tx_rst(seq_tx), .rx_rst(seq_rx),
    .rxa_rst(seq_rxa), .done);
  // ----
  // tasks
  // ----
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    hsize <= `TRC_HSIZE_WORD;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk({hresp, q}, {1'b0, e});
  endtask
  task automatic busy_len(output int b, output int p);
    b = 0;
    p = 0;
    for (int i = 0; i < 300 && busy !== 1'b1; i++) @(negedge ref_clk);
    while (busy === 1'b1 && b < 300) begin
      b++;
      p += (pll_rst_out === 1'b1);
      @(negedge ref_clk);
    end
  endtask
  task automatic report_and_stop;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----
  // stimulus
  // ----
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // hang guard: whole run needs some 250 cycles
  initial begin
    #200000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    {sys_rst, hsel, hwrite, block_powerdown, pll_pin, start} = 6'h20;
    {haddr, hwdata, htrans, hsize} = '0;
    {tb_tx, tb_rx, tb_rxa, reference_lock_mode, data_lock_mode} = '0;
    cdr_lock_raw = 8'hff;
    pll_lock_raw = 1'b1;
    error_cnt = 0;
    checked = 0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    start <= 1'b1;
    busy_len(n, m);
    chk(n, CAL);
    rd(`TRC_CTRL_OFS, 32'h0);
    rd(`TRC_CHRST_OFS, 32'h0);
    rd(`TRC_LOCK_OFS, 32'h0);
    rd(32'h20, 32'h0);
    for (int i = 0; i < 500 && done !== 1'b1; i++) @(negedge ref_clk);
    chk({pll_locked, freq_locked, tx_pcs_rst, rx_pcs_rst, cdr_rst}, 33'h1ff000000);
    rd(`TRC_STAT_OFS, 32'h0000ff05);
    start <= 1'b0;
    for (int k = 0; k < 3; k++) for (int c = 0; c < N; c++) begin
      @(posedge ref_clk);
      tb_tx <= (k == 0) ? 8'h01 << c : 8'h00;
      tb_rx <= (k == 1) ? 8'h01 << c : 8'h00;
      tb_rxa <= (k == 2) ? 8'h01 << c : 8'h00;
      @(negedge ref_clk);
      chk({deser_pd, rx_buf_pd, tx_buf_pd, cdr_rst, rx_pcs_rst, tx_pcs_rst},
        64'h1 << (k * 8 + c));
      repeat (2) @(posedge ref_clk);
      {tb_tx, tb_rx, tb_rxa} <= '0;
    end
    @(posedge ref_clk);
    block_powerdown <= 1'b1;
    repeat (2) @(negedge ref_clk);
    chk({deser_pd, rx_buf_pd, tx_buf_pd, cdr_rst, rx_pcs_rst, tx_pcs_rst, pll_rst_out,
      pll_locked}, {48'hffffffffffff, 2'b01});
    @(posedge ref_clk);
    block_powerdown <= 1'b0;
    // bond, then xaui: channels go in fours
    for (int b = `TRC_CTRL_BOND; b <= `TRC_CTRL_XAUI; b++) begin
      wr(`TRC_CTRL_OFS, 32'h1 << b);
      tb_tx <= 8'h20;
      tb_rx <= 8'h04;
      @(negedge ref_clk);
      chk({rx_pcs_rst, tx_pcs_rst}, 16'h0ff0);
      repeat (2) @(posedge ref_clk);
      {tb_tx, tb_rx} <= '0;
    end
    wr(`TRC_CTRL_OFS, 32'h0);
    pll_pin <= 1'b1;
    @(negedge ref_clk);
    chk({pll_rst_out, tx_pcs_rst, cdr_rst}, 17'h10000);
    @(negedge ref_clk);
    chk(pll_locked, 1'b0);
    @(posedge ref_clk);
    pll_pin <= 1'b0;
    wr(`TRC_CTRL_OFS, 32'h1);
    @(negedge ref_clk);
    chk(pll_rst_out, 1'b1);
    wr(`TRC_CTRL_OFS, 32'h0);
    wr(`TRC_CTRL_OFS, 32'h4);
    busy_len(n, m);
    chk({n[7:0], m[7:0]}, {8'(RC + PR), 8'(PR)});
    rd(`TRC_CTRL_OFS, 32'h0);
    // software resets stand one cycle beyond their clear
    wr(`TRC_CHRST_OFS, 32'h00040201);
    rd(`TRC_CHRST_OFS, 32'h00040201);
    wr(`TRC_CHRST_OFS, 32'h0);
    for (int i = 0; i < 2; i++) begin
      @(negedge ref_clk);
      chk({cdr_rst, rx_pcs_rst, tx_pcs_rst}, (i == 0) ? 24'h040201 : 24'h0);
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      reference_lock_mode <= {7'h0, i == 0};
      data_lock_mode <= {7'h0, i == 1};
      cdr_lock_raw <= 8'hfe;
      repeat (3) @(negedge ref_clk);
      rd(`TRC_STAT_OFS, ST_EXP[i]);
    end
    report_and_stop;
  end
endmodule // tb_transceiver_reset_control
bind trc_top trc_top_props #(.CHANNELS(CHANNELS)) u_props (.ref_clk, .sys_rst, .ce, .hsel,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .tx_digital_reset, .rx_digital_reset,
  .rx_analog_reset, .block_powerdown, .pll_reset, .pll_lock_raw, .reference_lock_mode,
  .data_lock_mode, .tx_pcs_rst, .rx_pcs_rst, .cdr_rst, .tx_buf_pd, .rx_buf_pd,
  .deser_pd, .pll_rst_out, .pll_locked, .freq_locked, .busy);
`default_nettype wire

// ### dv/trc_fabric_seq.sv
// partner: fabric reset sequencer driving the channel and pll resets
`timescale 1ns/1ps
`default_nettype none
module trc_fabric_seq #(
  parameter int N = 8,
  parameter int HOLD = 50,
  parameter int SETTLE = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic pll_locked,
  input wire logic busy,
  input wire logic [N-1:0] freq_locked,
  output logic pll_reset,
  output logic [N-1:0] tx_rst,
  output logic [N-1:0] rx_rst,
  output logic [N-1:0] rxa_rst,
  output logic done
);
  int st;
  int cnt;
  always @(posedge clk) begin
    cnt <= cnt + 1;
    if (rst) begin
      st <= 0;
      pll_reset <= 1'b0;
      tx_rst <= '1;
      rx_rst <= '1;
      rxa_rst <= '1;
      done <= 1'b0;
    end else begin
      case (st)
        0: if (start) begin
          st <= 1;
          cnt <= 0;
          pll_reset <= 1'b1;
        end
        1: if (cnt == HOLD - 1) begin
          st <= 2;
          pll_reset <= 1'b0;
        end
        2: if (pll_locked) begin
          st <= 3;
          tx_rst <= '0;
          cnt <= 0;
        end
        3: if (busy) cnt <= 0;
        else if (cnt == 1) begin
          st <= 4;
          rxa_rst <= '0;
          cnt <= 0;
        end
        4: if (!(&freq_locked)) cnt <= 0;
        else if (cnt == SETTLE) begin
          st <= 5;
          rx_rst <= '0;
          done <= 1'b1;
        end
        5: if (!start) st <= 6;
        else if (!pll_locked) begin
          st <= 2;
          tx_rst <= '1;
          rx_rst <= '1;
          done <= 1'b0;
        end
        default: st <= 6;
      endcase
    end
  end
endmodule // trc_fabric_seq
`default_nettype wire

// ### dv/trc_top_props.sv
// checker: reset fan-out, lock status, busy start and bus wait
`timescale 1ns/1ps
`default_nettype none
module trc_top_props #(
  parameter int CHANNELS = 4
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [CHANNELS-1:0] tx_digital_reset,
  input wire logic [CHANNELS-1:0] rx_digital_reset,
  input wire logic [CHANNELS-1:0] rx_analog_reset,
  input wire logic block_powerdown,
  input wire logic pll_reset,
  input wire logic pll_lock_raw,
  input wire logic [CHANNELS-1:0] reference_lock_mode,
  input wire logic [CHANNELS-1:0] data_lock_mode,
  input wire logic [CHANNELS-1:0] tx_pcs_rst,
  input wire logic [CHANNELS-1:0] rx_pcs_rst,
  input wire logic [CHANNELS-1:0] cdr_rst,
  input wire logic [CHANNELS-1:0] tx_buf_pd,
  input wire logic [CHANNELS-1:0] rx_buf_pd,
  input wire logic [CHANNELS-1:0] deser_pd,
  input wire logic pll_rst_out,
  input wire logic pll_locked,
  input wire logic [CHANNELS-1:0] freq_locked,
  input wire logic busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ----
  // properties
  // ----
  property p_tx; tx_digital_reset[0] |-> tx_pcs_rst[0]; endproperty
  a_tx: assert property (p_tx) else $error("tx reset not passed");
  property p_rx; rx_digital_reset[1] |-> rx_pcs_rst[1]; endproperty
  a_rx: assert property (p_rx) else $error("rx reset not passed");
  property p_ana; $rose(cdr_rst[2]) && !block_powerdown && !rx_digital_reset[2]
    |-> !rx_pcs_rst[2]; endproperty
  a_ana: assert property (p_ana) else $error("analog reset leaked");
  property p_pd; block_powerdown |-> &{tx_pcs_rst, rx_pcs_rst, cdr_rst, tx_buf_pd,
    rx_buf_pd, deser_pd}; endproperty
  a_pd: assert property (p_pd) else $error("power-down incomplete");
  property p_pdonly; !block_powerdown |-> !(|{tx_buf_pd, rx_buf_pd, deser_pd}); endproperty
  a_pdonly: assert property (p_pdonly) else $error("buffer down without cause");
  property p_pll; pll_reset |-> pll_rst_out; endproperty
  a_pll: assert property (p_pll) else $error("pll reset not passed");
  property p_lock; !sys_rst ##1 (pll_lock_raw && !pll_rst_out) [*2] |-> pll_locked;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not shown");
  property p_unlock; pll_rst_out |=> !pll_locked; endproperty
  a_unlock: assert property (p_unlock) else $error("lock shown in reset");
  property p_fdata; !sys_rst && data_lock_mode[0] && !cdr_rst[0] |=> freq_locked[0];
  endproperty
  a_fdata: assert property (p_fdata) else $error("data mode not locked");
  property p_fref; reference_lock_mode[0] && !data_lock_mode[0] |=> !freq_locked[0];
  endproperty
  a_fref: assert property (p_fref) else $error("ref mode shows lock");
  property p_bstart; $fell(sys_rst) |-> !busy ##1 busy ##1 busy; endproperty
  a_bstart: assert property (p_bstart) else $error("busy start wrong");
  property p_rwait; hsel && htrans[1] && hready && !hwrite && ce
    |=> !hreadyout ##1 hreadyout; endproperty
  a_rwait: assert property (p_rwait) else $error("read wait wrong");
  c_busy: cover property (!busy ##1 busy);
  c_pd: cover property (block_powerdown);
  c_auto: cover property (pll_rst_out && !pll_reset);
endmodule // trc_top_props
`default_nettype wire

// ### hdl/trc_busy.v
// offset cancellation and reconfiguration busy sequencer
`timescale 1ns/1ps
`default_nettype none
`include "trc_regs.vh"

module trc_busy #(
  parameter CAL_CYC = `TRC_CAL_CYC,
  parameter RCFG_CYC = `TRC_RCFG_CYC,
  parameter PLLR_CYC = `TRC_PLLR_CYC
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire ce,
  input wire reconfig_start,
  output reg busy,
  output reg pll_auto_rst,
  output reg cal_done
);

  localparam [2:0] ST_FIRST = 3'h0;
  localparam [2:0] ST_CAL = 3'h1;
  localparam [2:0] ST_IDLE = 3'h2;
  localparam [2:0] ST_RCFG = 3'h3;
  localparam [2:0] ST_PLLR = 3'h4;

  reg [2:0] state_reg;
  reg [15:0] cnt_reg;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= ST_FIRST;
      cnt_reg <= 16'h0000;
      busy <= 1'b0;
      pll_auto_rst <= 1'b0;
      cal_done <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        ST_FIRST: begin
          state_reg <= ST_CAL;
          busy <= 1'b1;
          cnt_reg <= CAL_CYC[15:0] - 16'h0001;
        end
        ST_CAL: begin
          if (cnt_reg == 16'h0000) begin
            state_reg <= ST_IDLE;
            busy <= 1'b0;
            cal_done <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        ST_IDLE: begin
          if (reconfig_start) begin
            state_reg <= ST_RCFG;
            busy <= 1'b1;
            cnt_reg <= RCFG_CYC[15:0] - 16'h0001;
          end
        end
        ST_RCFG: begin
          if (cnt_reg == 16'h0000) begin
            state_reg <= ST_PLLR;
            pll_auto_rst <= 1'b1;
            cnt_reg <= PLLR_CYC[15:0] - 16'h0001;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        ST_PLLR: begin
          if (cnt_reg == 16'h0000) begin
            state_reg <= ST_IDLE;
            busy <= 1'b0;
            pll_auto_rst <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          busy <= 1'b0;
          pll_auto_rst <= 1'b0;
        end
      endcase
    end
  end

endmodule // trc_busy

`default_nettype wire

// ### hdl/trc_chan.v
// one transceiver channel: reset fan-out, power-down and receiver lock status
`timescale 1ns/1ps
`default_nettype none
`include "trc_regs.vh"

module trc_chan (
  input wire ref_clk,
  input wire sys_rst,
  input wire ce,
  input wire tx_rst_req,
  input wire rx_rst_req,
  input wire rxa_rst_req,
  input wire pwrdn,
  input wire ref_lock_ctl,
  input wire data_lock_ctl,
  input wire cdr_lock_raw,
  output wire tx_pcs_rst,
  output wire rx_pcs_rst,
  output wire cdr_rst,
  output wire tx_buf_pd,
  output wire rx_buf_pd,
  output wire deser_pd,
  output reg freq_locked,
  output wire [1:0] lock_mode
);

  // ----------------------------------------
  // lock mode decode
  // ----------------------------------------
  function [1:0] mode_of;
    input ref_ctl;
    input data_ctl;
    begin
      if (data_ctl)
        mode_of = `TRC_MODE_LTD;
      else if (ref_ctl)
        mode_of = `TRC_MODE_LTR;
      else
        mode_of = `TRC_MODE_AUTO;
    end
  endfunction

  assign lock_mode = mode_of(ref_lock_ctl, data_lock_ctl);

  // ----------------------------------------
  // reset and power-down fan-out
  // ----------------------------------------
  // no clock in the path: assertion and release need no alignment
  // async acceptance
  assign tx_pcs_rst = tx_rst_req | pwrdn;
  assign rx_pcs_rst = rx_rst_req | pwrdn;
  assign cdr_rst = rxa_rst_req | pwrdn;
  assign tx_buf_pd = pwrdn;
  assign rx_buf_pd = pwrdn;
  assign deser_pd = pwrdn;

  // ----------------------------------------
  // frequency lock status
  // ----------------------------------------
  // high in lock-to-data
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      freq_locked <= 1'b0;
    end else if (ce) begin
      if (cdr_rst)
        freq_locked <= 1'b0;
      else if (lock_mode == `TRC_MODE_LTD)
        freq_locked <= 1'b1;
      else if (lock_mode == `TRC_MODE_AUTO)
        freq_locked <= cdr_lock_raw;
      else
        freq_locked <= 1'b0;
    end
  end

endmodule // trc_chan

`default_nettype wire

// ### hdl/trc_regs.vh
// register map, field positions, reset values and timing counts of the reset controller
`ifndef TRC_REGS_VH
`define TRC_REGS_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define TRC_CTRL_OFS 12'h000
`define TRC_CHRST_OFS 12'h004
`define TRC_LOCK_OFS 12'h008
`define TRC_STAT_OFS 12'h00c
`define TRC_PIN_OFS 12'h010

// ----------------------------------------
// field positions
// ----------------------------------------
`define TRC_CTRL_PLLRST 0
`define TRC_CTRL_PWRDN 1
`define TRC_CTRL_RECFG 2
`define TRC_CTRL_BOND 3
`define TRC_CTRL_XAUI 4
`define TRC_CHRST_TX 0
`define TRC_CHRST_RX 8
`define TRC_CHRST_RXA 16
`define TRC_LOCK_REF 0
`define TRC_LOCK_DATA 8
`define TRC_STAT_PLLLOCK 0
`define TRC_STAT_BUSY 1
`define TRC_STAT_CALDONE 2
`define TRC_STAT_FREQ 8
`define TRC_STAT_MODE 16
`define TRC_PIN_PLLRST 0
`define TRC_PIN_PWRDN 1
`define TRC_PIN_TX 8
`define TRC_PIN_RX 16
`define TRC_PIN_RXA 24

// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define TRC_CTRL_RST 5'h00
`define TRC_LOCK_RST 32'h0000_0000
`define TRC_MODE_AUTO 2'h0
`define TRC_MODE_LTR 2'h1
`define TRC_MODE_LTD 2'h2
`define TRC_BOND_GROUP 4
`define TRC_HSIZE_WORD 3'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define TRC_CLK_NS 20
`define TRC_CAL_NS 20000
`define TRC_RCFG_NS 2000
`define TRC_PLLR_NS 1000
`define TRC_CAL_CYC ((`TRC_CAL_NS + `TRC_CLK_NS - 1) / `TRC_CLK_NS)
`define TRC_RCFG_CYC ((`TRC_RCFG_NS + `TRC_CLK_NS - 1) / `TRC_CLK_NS)
`define TRC_PLLR_CYC ((`TRC_PLLR_NS + `TRC_CLK_NS - 1) / `TRC_CLK_NS)

`endif

// ### hdl/trc_top.v
// transceiver reset and power-down controller with ahb-lite register slave
//
// How it works
// - channel resets and block power-down act without any clock alignment
// - every channel has own resets; one power-down covers the block
// - transmit digital reset holds all transmit coding sublayer logic
// - receive digital reset holds all receive coding sublayer logic
// - receive analog reset touches only clock recovery: that channel's, or its whole group's when bonded
// - pll reset hits only the plls; also automatic after reconfiguration
// - block power-down shuts every channel, independent of other resets
// - buffers and deserializer follow power-down only; plls pll reset only
// - pll lock output high while transmit pll is locked
// - frequency lock high in lock-to-data, low in lock-to-reference
// - busy low first cycle, high from second during offset cancellation
// - busy also high for the whole of a reconfiguration
// - xaui bonds channels in fours; other modes bonded or not
// - lock mode from two controls: ref-only, data, or automatic
`timescale 1ns/1ps
`default_nettype none
`include "trc_regs.vh"

module trc_top #(
  parameter CHANNELS = 4,
  parameter CAL_CYC = `TRC_CAL_CYC,
  parameter RCFG_CYC = `TRC_RCFG_CYC,
  parameter PLLR_CYC = `TRC_PLLR_CYC
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire ce,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output reg [31:0] hrdata,
  output wire hresp,
  input wire [CHANNELS-1:0] tx_digital_reset,
  input wire [CHANNELS-1:0] rx_digital_reset,
  input wire [CHANNELS-1:0] rx_analog_reset,
  input wire block_powerdown,
  input wire pll_reset,
  input wire pll_lock_raw,
  input wire [CHANNELS-1:0] cdr_lock_raw,
  input wire [CHANNELS-1:0] reference_lock_mode,
  input wire [CHANNELS-1:0] data_lock_mode,
  output wire [CHANNELS-1:0] tx_pcs_rst,
  output wire [CHANNELS-1:0] rx_pcs_rst,
  output wire [CHANNELS-1:0] cdr_rst,
  output wire [CHANNELS-1:0] tx_buf_pd,
  output wire [CHANNELS-1:0] rx_buf_pd,
  output wire [CHANNELS-1:0] deser_pd,
  output wire pll_rst_out,
  output reg pll_locked,
  output wire [CHANNELS-1:0] freq_locked,
  output wire busy
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg [4:0] ctrl_reg;
  reg [CHANNELS-1:0] sw_tx_reg;
  reg [CHANNELS-1:0] sw_rx_reg;
  reg [CHANNELS-1:0] sw_rxa_reg;
  reg [CHANNELS-1:0] sw_tx_d_reg;
  reg [CHANNELS-1:0] sw_rx_d_reg;
  reg [CHANNELS-1:0] sw_rxa_d_reg;
  reg [CHANNELS-1:0] sw_ref_reg;
  reg [CHANNELS-1:0] sw_data_reg;
  reg recfg_go_reg;
  reg wr_pend_reg;
  reg rd_pend_reg;
  reg [11:0] addr_reg;
  reg [31:0] rd_next;
  wire addr_phase;
  wire pwrdn;
  wire bonded;
  wire cal_done;
  wire pll_auto_rst;
  wire [CHANNELS-1:0] tx_req;
  wire [CHANNELS-1:0] rx_req;
  wire [CHANNELS-1:0] rxa_req;
  wire [CHANNELS-1:0] tx_own;
  wire [CHANNELS-1:0] rx_own;
  wire [CHANNELS-1:0] rxa_own;
  wire [2*CHANNELS-1:0] mode_vec;

  // ----------------------------------------
  // bonding group merge
  // ----------------------------------------
  // a reset on any member of a bonded group resets the whole group together
  function grp_or;
    input [CHANNELS-1:0] v;
    input integer ch;
    input bond;
    integer k;
    begin
      grp_or = v[ch];
      if (bond) begin
        for (k = 0; k < CHANNELS; k = k + 1) begin
          if ((k / `TRC_BOND_GROUP) == (ch / `TRC_BOND_GROUP))
            grp_or = grp_or | v[k];
        end
      end
    end
  endfunction

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  // reads take one wait state so a write just before is always seen
  assign addr_phase = hsel & htrans[1] & hready & ce;
  assign hreadyout = ce & ~rd_pend_reg;
  assign hresp = 1'b0;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 12'h000;
    end else if (ce) begin
      if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
      end else if (addr_phase) begin
        wr_pend_reg <= hwrite & (hsize == `TRC_HSIZE_WORD);
        rd_pend_reg <= ~hwrite;
        addr_reg <= haddr[11:0];
      end else if (hready) begin
        wr_pend_reg <= 1'b0;
      end
    end
  end

  always @* begin
    rd_next = 32'h0000_0000;
    case (addr_reg)
      `TRC_CTRL_OFS: begin
        rd_next[4:0] = ctrl_reg;
        rd_next[`TRC_CTRL_RECFG] = 1'b0;
      end
      `TRC_CHRST_OFS: begin
        rd_next[`TRC_CHRST_TX +: CHANNELS] = sw_tx_reg;
        rd_next[`TRC_CHRST_RX +: CHANNELS] = sw_rx_reg;
        rd_next[`TRC_CHRST_RXA +: CHANNELS] = sw_rxa_reg;
      end
      `TRC_LOCK_OFS: begin
        rd_next[`TRC_LOCK_REF +: CHANNELS] = sw_ref_reg;
        rd_next[`TRC_LOCK_DATA +: CHANNELS] = sw_data_reg;
      end
      `TRC_STAT_OFS: begin
        rd_next[`TRC_STAT_PLLLOCK] = pll_locked;
        rd_next[`TRC_STAT_BUSY] = busy;
        rd_next[`TRC_STAT_CALDONE] = cal_done;
        rd_next[`TRC_STAT_FREQ +: CHANNELS] = freq_locked;
        rd_next[`TRC_STAT_MODE +: 2*CHANNELS] = mode_vec;
      end
      `TRC_PIN_OFS: begin
        rd_next[`TRC_PIN_PLLRST] = pll_reset;
        rd_next[`TRC_PIN_PWRDN] = block_powerdown;
        rd_next[`TRC_PIN_TX +: CHANNELS] = tx_digital_reset;
        rd_next[`TRC_PIN_RX +: CHANNELS] = rx_digital_reset;
        rd_next[`TRC_PIN_RXA +: CHANNELS] = rx_analog_reset;
      end
      default: begin
        rd_next = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && rd_pend_reg) begin
      hrdata <= rd_next;
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_reg <= `TRC_CTRL_RST;
      sw_tx_reg <= {CHANNELS{1'b0}};
      sw_rx_reg <= {CHANNELS{1'b0}};
      sw_rxa_reg <= {CHANNELS{1'b0}};
      sw_ref_reg <= {CHANNELS{1'b0}};
      sw_data_reg <= {CHANNELS{1'b0}};
      recfg_go_reg <= 1'b0;
    end else if (ce) begin
      recfg_go_reg <= 1'b0;
      if (wr_pend_reg && hready) begin
        case (addr_reg)
          `TRC_CTRL_OFS: begin
            ctrl_reg <= hwdata[4:0];
            ctrl_reg[`TRC_CTRL_RECFG] <= 1'b0;
            recfg_go_reg <= hwdata[`TRC_CTRL_RECFG];
          end
          `TRC_CHRST_OFS: begin
            sw_tx_reg <= hwdata[`TRC_CHRST_TX +: CHANNELS];
            sw_rx_reg <= hwdata[`TRC_CHRST_RX +: CHANNELS];
            sw_rxa_reg <= hwdata[`TRC_CHRST_RXA +: CHANNELS];
          end
          `TRC_LOCK_OFS: begin
            sw_ref_reg <= hwdata[`TRC_LOCK_REF +: CHANNELS];
            sw_data_reg <= hwdata[`TRC_LOCK_DATA +: CHANNELS];
          end
          default: begin
            recfg_go_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // software reset stretch
  // ----------------------------------------
  // a one-cycle software pulse would be too short for the channel logic,
  // so each bit is ored with its previous value
  // two-cycle minimum
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      sw_tx_d_reg <= {CHANNELS{1'b0}};
      sw_rx_d_reg <= {CHANNELS{1'b0}};
      sw_rxa_d_reg <= {CHANNELS{1'b0}};
    end else if (ce) begin
      sw_tx_d_reg <= sw_tx_reg;
      sw_rx_d_reg <= sw_rx_reg;
      sw_rxa_d_reg <= sw_rxa_reg;
    end
  end

  assign tx_own = tx_digital_reset | sw_tx_reg | sw_tx_d_reg;
  assign rx_own = rx_digital_reset | sw_rx_reg | sw_rx_d_reg;
  assign rxa_own = rx_analog_reset | sw_rxa_reg | sw_rxa_d_reg;

  assign pwrdn = block_powerdown | ctrl_reg[`TRC_CTRL_PWRDN];

  assign bonded = ctrl_reg[`TRC_CTRL_BOND] | ctrl_reg[`TRC_CTRL_XAUI];

  // ----------------------------------------
  // pll reset and lock
  // ----------------------------------------
  // pll reset sources
  assign pll_rst_out = pll_reset | ctrl_reg[`TRC_CTRL_PLLRST] | pll_auto_rst;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pll_locked <= 1'b0;
    end else if (ce) begin
      pll_locked <= pll_lock_raw & ~pll_rst_out;
    end
  end

  // ----------------------------------------
  // busy sequencer
  // ----------------------------------------
  trc_busy #(
    .CAL_CYC(CAL_CYC),
    .RCFG_CYC(RCFG_CYC),
    .PLLR_CYC(PLLR_CYC)
  ) u_busy (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .reconfig_start(recfg_go_reg),
    .busy(busy),
    .pll_auto_rst(pll_auto_rst),
    .cal_done(cal_done)
  );

  // ----------------------------------------
  // channels
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : g_chan
      assign tx_req[gi] = grp_or(tx_own, gi, bonded);
      assign rx_req[gi] = grp_or(rx_own, gi, bonded);
      assign rxa_req[gi] = grp_or(rxa_own, gi, bonded);

      trc_chan u_chan (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .tx_rst_req(tx_req[gi]),
        .rx_rst_req(rx_req[gi]),
        .rxa_rst_req(rxa_req[gi]),
        .pwrdn(pwrdn),
        .ref_lock_ctl(reference_lock_mode[gi] | sw_ref_reg[gi]),
        .data_lock_ctl(data_lock_mode[gi] | sw_data_reg[gi]),
        .cdr_lock_raw(cdr_lock_raw[gi]),
        .tx_pcs_rst(tx_pcs_rst[gi]),
        .rx_pcs_rst(rx_pcs_rst[gi]),
        .cdr_rst(cdr_rst[gi]),
        .tx_buf_pd(tx_buf_pd[gi]),
        .rx_buf_pd(rx_buf_pd[gi]),
        .deser_pd(deser_pd[gi]),
        .freq_locked(freq_locked[gi]),
        .lock_mode(mode_vec[2*gi +: 2])
      );
    end
  endgenerate

endmodule // trc_top

`default_nettype wire
